// [core/itsb_core.sv]
// Input-triggered segment branch: arms on a register write, watches one input for a falling edge,
// then requests a segment load and, when multitasking is off, a move abort.
// Assumes asynchronous input pins and an AXI4-Lite master on aclk.
//
// Chosen here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
module itsb_core #(
    parameter int NUM_INPUTS = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [NUM_INPUTS-1:0] input_pins,
    input wire logic [3:0] s_axi_awaddr_unused_hi,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output itsb_pkg::itsb_branch_s branch_req,
    output logic irq
);
    import itsb_pkg::*;

    localparam int SEL_W = 8;

    // Selector field is SEL_W bits wide, so at most 256 inputs
    if (NUM_INPUTS < 1 || NUM_INPUTS > 256) begin : g_bad_width
        $error("NUM_INPUTS must be 1 to 256");
    end

    // ****************************************
    // Input synchroniser and edge detect
    // ****************************************
    logic [NUM_INPUTS-1:0] sync1_reg;
    logic [NUM_INPUTS-1:0] sync2_reg;
    logic [NUM_INPUTS-1:0] prev_reg;
    logic [NUM_INPUTS-1:0] fall;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_reg <= '1;
            sync2_reg <= '1;
            prev_reg <= '1;
        end else begin
            sync1_reg <= input_pins;
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_INPUTS; gi++) begin : g_edge
            assign fall[gi] = prev_reg[gi] & ~sync2_reg[gi];
        end
    endgenerate

    // ****************************************
    // AXI4-Lite write path
    // ****************************************
    logic aw_held_reg;
    logic w_held_reg;
    logic [7:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic wr_do;
    logic wr_hit;

    assign wr_do = aw_held_reg && w_held_reg && !s_axi_bvalid;
    assign wr_hit = awaddr_reg == ITSB_ARM_OFS || awaddr_reg == ITSB_MT_OFS
        || awaddr_reg == ITSB_STATUS_OFS || awaddr_reg == ITSB_IRQ_STAT_OFS
        || awaddr_reg == ITSB_IRQ_MASK_OFS;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= ITSB_AXI_OKAY;
        end else begin
            s_axi_awready <= !aw_held_reg && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_held_reg && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (wr_do) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? ITSB_AXI_OKAY : ITSB_AXI_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    logic wr_arm;
    logic wr_mt;
    logic wr_stat;
    logic wr_mask;
    assign wr_arm = wr_do && awaddr_reg == ITSB_ARM_OFS && wstrb_reg[1];
    assign wr_mt = wr_do && awaddr_reg == ITSB_MT_OFS && wstrb_reg[0];
    assign wr_stat = wr_do && awaddr_reg == ITSB_IRQ_STAT_OFS && wstrb_reg[0];
    assign wr_mask = wr_do && awaddr_reg == ITSB_IRQ_MASK_OFS && wstrb_reg[0];

    // ****************************************
    // Arm state and branch request
    // ****************************************
    logic armed_reg;
    logic [SEL_W-1:0] sel_reg;
    logic multitask_switch_reg;
    logic fire;

    logic [NUM_INPUTS-1:0] hit;

    // Compare per input so a selector beyond the last input never indexes out of range
    generate
        for (gi = 0; gi < NUM_INPUTS; gi++) begin : g_hit
            assign hit[gi] = fall[gi] && sel_reg == SEL_W'(gi);
        end
    endgenerate

    assign fire = armed_reg && |hit;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            multitask_switch_reg <= ITSB_MT_RESET;
        end else if (wr_mt) begin
            multitask_switch_reg <= wdata_reg[0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            armed_reg <= 1'b0;
            sel_reg <= '0;
        end else if (wr_arm) begin
            armed_reg <= wdata_reg[ITSB_ARM_EN_BIT];
            sel_reg <= wdata_reg[ITSB_ARM_SEL_LSB +: SEL_W];
        end else if (fire) begin
            armed_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            branch_req <= '0;
        end else begin
            branch_req.load_segment <= fire;
            branch_req.segment <= ITSB_BRANCH_SEGMENT;
            branch_req.abort_move <= fire && !multitask_switch_reg;
        end
    end

    // ****************************************
    // Interrupt status and mask
    // ****************************************
    logic [ITSB_NUM_EVENTS-1:0] irq_stat_reg;
    logic [ITSB_NUM_EVENTS-1:0] irq_mask_reg;
    logic [ITSB_NUM_EVENTS-1:0] ev;

    assign ev[ITSB_EV_FIRE_BIT] = fire;
    assign ev[ITSB_EV_ABORT_BIT] = fire && !multitask_switch_reg;

    // Set wins over a write-one clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_reg <= '0;
            irq_mask_reg <= '0;
            irq <= 1'b0;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~(wr_stat ? wdata_reg[ITSB_NUM_EVENTS-1:0] : '0)) | ev;
            if (wr_mask) begin
                irq_mask_reg <= wdata_reg[ITSB_NUM_EVENTS-1:0];
            end
            irq <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // ****************************************
    // AXI4-Lite read path
    // ****************************************
    logic [31:0] rd_mux;
    logic rd_hit;

    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        case ({s_axi_araddr[7:2], 2'b00})
            ITSB_ARM_OFS: begin
                rd_mux[ITSB_ARM_SEL_LSB +: SEL_W] = sel_reg;
                rd_mux[ITSB_ARM_EN_BIT] = armed_reg;
            end
            ITSB_MT_OFS: rd_mux[0] = multitask_switch_reg;
            ITSB_STATUS_OFS: begin
                rd_mux[ITSB_ST_ARMED_BIT] = armed_reg;
                rd_mux[ITSB_ST_BUSY_BIT] = branch_req.load_segment;
            end
            ITSB_IRQ_STAT_OFS: rd_mux[ITSB_NUM_EVENTS-1:0] = irq_stat_reg;
            ITSB_IRQ_MASK_OFS: rd_mux[ITSB_NUM_EVENTS-1:0] = irq_mask_reg;
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= ITSB_AXI_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= rd_hit ? ITSB_AXI_OKAY : ITSB_AXI_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    a_fire_loads: assert property (@(posedge aclk) disable iff (!aresetn)
        fire |=> branch_req.load_segment && branch_req.segment == ITSB_BRANCH_SEGMENT)
        else $error("segment load not requested after trigger");
    a_arm_write: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_arm && wdata_reg[ITSB_ARM_EN_BIT] |=> armed_reg)
        else $error("arm write did not arm");
    a_fire_disarms: assert property (@(posedge aclk) disable iff (!aresetn)
        fire && !wr_arm |=> !armed_reg ##1 !branch_req.load_segment || armed_reg)
        else $error("still armed after firing");
    a_sel_replaced: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_arm |=> sel_reg == $past(wdata_reg[SEL_W-1:0]))
        else $error("selection not replaced");
    a_disarm_write: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_arm && !wdata_reg[ITSB_ARM_EN_BIT] |=> !armed_reg ##1 !branch_req.load_segment)
        else $error("disarm write ignored");
    a_abort_off: assert property (@(posedge aclk) disable iff (!aresetn)
        fire && !multitask_switch_reg |=> branch_req.abort_move)
        else $error("move not aborted with multitasking off");
    a_keep_move: assert property (@(posedge aclk) disable iff (!aresetn)
        branch_req.abort_move |-> branch_req.load_segment && !$past(multitask_switch_reg))
        else $error("abort with multitasking on");
    a_edge_detect: assert property (@(posedge aclk) disable iff (!aresetn)
        branch_req.load_segment |-> $past(armed_reg, 1) && !$past(branch_req.load_segment))
        else $error("trigger without armed edge");
    a_keep_running: assert property (@(posedge aclk) disable iff (!aresetn)
        fire && multitask_switch_reg |=> branch_req.load_segment && !branch_req.abort_move)
        else $error("move aborted with multitasking on");
    a_mt_write: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_mt |=> multitask_switch_reg == $past(wdata_reg[0]))
        else $error("multitask switch not written");
    a_one_trigger: assert property (@(posedge aclk) disable iff (!aresetn)
        fire && !wr_arm |=> !fire)
        else $error("one edge fired twice");

endmodule : itsb_core

// [core/itsb_pkg.sv]
// Package for the input-triggered segment branch block.
// Assumes a single 100 MHz clock and an AXI4-Lite register bus with 32-bit data.
package itsb_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] ITSB_ARM_OFS = 8'h00;
    localparam logic [7:0] ITSB_MT_OFS = 8'h04;
    localparam logic [7:0] ITSB_STATUS_OFS = 8'h08;
    localparam logic [7:0] ITSB_IRQ_STAT_OFS = 8'h0c;
    localparam logic [7:0] ITSB_IRQ_MASK_OFS = 8'h10;

    // ****************************************
    // Field positions and values
    // ****************************************
    localparam int ITSB_ARM_SEL_LSB = 0;
    localparam int ITSB_ARM_EN_BIT = 8;
    localparam int ITSB_ST_ARMED_BIT = 0;
    localparam int ITSB_ST_BUSY_BIT = 1;
    localparam int ITSB_EV_FIRE_BIT = 0;
    localparam int ITSB_EV_ABORT_BIT = 1;
    localparam int ITSB_NUM_EVENTS = 2;
    localparam logic [3:0] ITSB_BRANCH_SEGMENT = 4'ha;
    localparam logic ITSB_MT_RESET = 1'b0;
    localparam logic [1:0] ITSB_AXI_OKAY = 2'b00;
    localparam logic [1:0] ITSB_AXI_SLVERR = 2'b10;

    // Request toward the program sequencer and motion generator
    typedef struct packed {
        logic load_segment;
        logic [3:0] segment;
        logic abort_move;
    } itsb_branch_s;

endpackage : itsb_pkg

// [verif/itsb_partner.sv]
// Model of the input line driver and the program sequencer.
// Assumes one aclk domain; pins idle high and each level lasts at least 3 cycles.
`timescale 1ns/10ps
module itsb_partner
    import itsb_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input itsb_pkg::itsb_branch_s branch_req,
    output logic [7:0] input_pins
);
    logic [7:0] loads;
    logic [7:0] aborts;
    logic [3:0] seg;

    initial input_pins = 8'hff;

    task automatic drop(input int i);
        @(posedge aclk);
        input_pins[i] <= 1'b0;
        repeat (6) @(posedge aclk);
        input_pins[i] <= 1'b1;
        repeat (6) @(posedge aclk);
    endtask : drop

    // Sequencer side: count loads and aborts
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            loads <= 8'h00;
            aborts <= 8'h00;
            seg <= 4'h0;
        end else if (branch_req.load_segment) begin
            loads <= loads + 8'h01;
            aborts <= aborts + {7'h00, branch_req.abort_move};
            seg <= branch_req.segment;
        end
    end
endmodule : itsb_partner

// [verif/tb_input_triggered_segment_branch.sv]
// Testbench for the input-triggered segment branch block.
// Assumes AXI4-Lite access on aclk and the partner model on the input pins.
`timescale 1ns/10ps
module tb_input_triggered_segment_branch;
    import itsb_pkg::*;
    // ****************************************
    // Signals and instances
    // ****************************************
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] input_pins;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'hf, awhi = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp;
    itsb_branch_s branch_req;
    int bad_count = 0;
    int tests_run = 0;
    int cyc = 0;

    always #5 aclk = ~aclk;

    itsb_core uut (.aclk(aclk), .aresetn(aresetn), .input_pins(input_pins), .s_axi_awaddr_unused_hi(awhi),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .branch_req(branch_req), .irq(irq));
    itsb_partner p (.aclk(aclk), .aresetn(aresetn), .branch_req(branch_req), .input_pins(input_pins));

    // ****************************************
    // Tasks
    // ****************************************
    task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : cmp

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = ITSB_AXI_OKAY);
        logic got;
        got = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!got) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                got = 1'b1;
                bready <= 1'b0;
                cmp("bresp", {30'h0, er}, {30'h0, bresp});
            end
        end
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er = ITSB_AXI_OKAY);
        logic got;
        got = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!got) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                got = 1'b1;
                rready <= 1'b0;
                cmp("rdata", ed, rdata);
                cmp("rresp", {30'h0, er}, {30'h0, rresp});
            end
        end
    endtask : axi_rd

    task automatic irq_is(input logic e);
        repeat (4) @(posedge aclk);
        cmp("irq", {31'h0, e}, {31'h0, irq});
    endtask : irq_is

    task automatic print_verdict;
        $display("checks %0d errors %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict

    always @(posedge aclk) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            print_verdict;
        end
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(ITSB_STATUS_OFS, 32'h0);
        axi_rd(ITSB_MT_OFS, 32'h0);
        axi_rd(8'h14, 32'h0, ITSB_AXI_SLVERR);
        axi_wr(ITSB_ARM_OFS, 32'h103);
        axi_rd(ITSB_STATUS_OFS, 32'h1);
        p.drop(2);
        cmp("loads", 32'h0, p.loads);
        p.drop(3);
        cmp("loads", 32'h1, p.loads);
        cmp("aborts", 32'h1, p.aborts);
        cmp("segment", 32'ha, p.seg);
        axi_rd(ITSB_STATUS_OFS, 32'h0);
        p.drop(3);
        cmp("loads", 32'h1, p.loads);
        axi_rd(ITSB_IRQ_STAT_OFS, 32'h3);
        irq_is(1'b0);
        axi_wr(ITSB_IRQ_MASK_OFS, 32'h2);
        irq_is(1'b1);
        axi_wr(ITSB_IRQ_STAT_OFS, 32'h2);
        irq_is(1'b0);
        axi_rd(ITSB_IRQ_STAT_OFS, 32'h1);
        axi_wr(ITSB_IRQ_MASK_OFS, 32'h1);
        irq_is(1'b1);
        axi_wr(ITSB_IRQ_STAT_OFS, 32'h1);
        irq_is(1'b0);
        axi_wr(ITSB_MT_OFS, 32'h1);
        axi_rd(ITSB_MT_OFS, 32'h1);
        axi_wr(ITSB_ARM_OFS, 32'h103);
        axi_wr(ITSB_ARM_OFS, 32'h105);
        p.drop(3);
        cmp("loads", 32'h1, p.loads);
        p.drop(5);
        cmp("loads", 32'h2, p.loads);
        cmp("aborts", 32'h1, p.aborts);
        axi_wr(ITSB_ARM_OFS, 32'h105);
        axi_wr(ITSB_ARM_OFS, 32'h0);
        axi_rd(ITSB_STATUS_OFS, 32'h0);
        p.drop(5);
        cmp("loads", 32'h2, p.loads);
        // Arm write without the enable byte lane is dropped
        wstrb <= 4'h1;
        axi_wr(ITSB_ARM_OFS, 32'h103);
        axi_rd(ITSB_STATUS_OFS, 32'h0);
        wstrb <= 4'hf;
        awhi <= 4'ha;
        axi_wr(ITSB_ARM_OFS, 32'h103);
        axi_rd(ITSB_ARM_OFS, 32'h103);
        p.drop(3);
        cmp("loads", 32'h3, p.loads);
        cmp("aborts", 32'h1, p.aborts);
        irq_is(1'b1);
        // Second reset in mid-run
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(ITSB_MT_OFS, 32'h0);
        axi_rd(ITSB_ARM_OFS, 32'h0);
        axi_rd(ITSB_IRQ_STAT_OFS, 32'h0);
        irq_is(1'b0);
        cmp("loads", 32'h0, p.loads);
        print_verdict;
    end
endmodule : tb_input_triggered_segment_branch
